// file: core/cwd_decoder.v
// Configuration word decoder: holds the configuration word and test space cells,
// and drives the static option outputs and memory-access guards.
// Assumes a programmer port on mclk and a programming-mode pin from outside.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "cwd_defs.vh"

module cwd_decoder (
  input  wire                    mclk,
  input  wire                    rst_n,
  input  wire                    prog_mode_pin,
  input  wire [`CWD_ADDR_W-1:0]  addr,
  input  wire [`CWD_WORD_W-1:0]  wdata,
  input  wire                    wr_stb,
  input  wire                    rd_stb,
  output reg  [`CWD_WORD_W-1:0]  rdata,
  output reg                     oscillator_source_select,
  output reg                     crystal_oscillator_mode,
  output reg                     watchdog_enable,
  output reg                     powerup_timer_enable_n,
  output reg                     program_protect_hi,
  output reg                     program_protect_lo,
  output reg                     calib_space_protect,
  output reg                     prog_read_allow,
  output reg                     prog_write_allow,
  output reg                     calib_write_allow,
  output reg                     prog_write_pulse,
  output reg                     access_error
);

  // ****************************************************************************
  // Programming-mode pin synchroniser
  // ****************************************************************************
  wire prog_mode;

  cwd_pin_sync #(
    .RESET_VAL (1'b0)
  ) u_prog_sync (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .pin_in    (prog_mode_pin),
    .level_out (prog_mode)
  );

  // ****************************************************************************
  // Address decode helpers
  // ****************************************************************************
  function in_range;
    input [`CWD_ADDR_W-1:0] a;
    input [`CWD_ADDR_W-1:0] lo;
    input [`CWD_ADDR_W-1:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  wire in_test  = in_range(addr, `CWD_TEST_LO, `CWD_TEST_HI);
  wire in_cal   = in_range(addr, `CWD_CAL_LO, `CWD_CAL_HI);
  wire in_cfg   = (addr == `CWD_CFG_ADDR);
  wire in_prog  = in_range(addr, {`CWD_ADDR_W{1'b0}}, `CWD_PROG_TOP);

  // Test cells are only the eight words 2000h..2007h; the rest of test space reads erased
  wire in_cell  = in_cal | in_cfg;
  wire [2:0] cell_idx = addr[2:0];

  // ****************************************************************************
  // Access qualification
  // ****************************************************************************
  reg  [`CWD_WORD_W-1:0] cfg_reg;
  wire prog_ok_now = cfg_reg[`CWD_BIT_PROGRAM_PROTECT_HI] & cfg_reg[`CWD_BIT_PROGRAM_PROTECT_LO];
  wire cal_wr_ok   = cfg_reg[`CWD_BIT_CPC];

  // Test space needs programming mode; calibration writes need CALIB_SPACE_PROTECT; config word writable in programming mode whatever the protect bits
  wire test_ok  = in_test & prog_mode;
  wire cell_wr  = wr_stb & test_ok & in_cell & (in_cfg | cal_wr_ok);
  wire prog_wr  = wr_stb & in_prog & prog_mode & prog_ok_now;
  wire bad_wr   = wr_stb & ~cell_wr & ~prog_wr;
  wire bad_rd   = rd_stb & ((in_test & ~prog_mode) | (in_prog & ~prog_ok_now));

  // Reserved bits of the config word are never cleared, so they stay one
  wire [`CWD_WORD_W-1:0] wr_word = in_cfg ? (wdata | `CWD_RSVD_MASK) : wdata;

  // ****************************************************************************
  // Test-space cells
  // ****************************************************************************
  wire [`CWD_WORD_W-1:0] cell_rdata;

  cwd_word_mem #(
    .DEPTH_W (3)
  ) u_mem (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (cell_wr),
    .wr_addr (cell_idx),
    .wr_data (wr_word),
    .rd_addr (cell_idx),
    .rd_data (cell_rdata)
  );

  // ****************************************************************************
  // Shadow of the configuration word
  // ****************************************************************************
  // Kept beside the memory so decode needs no read port; programming only clears bits
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= `CWD_ERASED;
    end else if (cell_wr && in_cfg) begin
      cfg_reg <= cfg_reg & wr_word;
    end
  end

  // ****************************************************************************
  // Read path
  // ****************************************************************************
  reg rd_pend_reg;
  reg rd_cell_reg;
  reg rd_ok_reg;

  // Remember what kind of read was issued; data appear one cycle after the strobe
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_reg <= 1'b0;
      rd_cell_reg <= 1'b0;
      rd_ok_reg   <= 1'b0;
    end else begin
      rd_pend_reg <= rd_stb;
      rd_cell_reg <= in_cell;
      rd_ok_reg   <= rd_stb & test_ok;
    end
  end

  // Blocked or outside reads return zero; cells give their data, other test space reads erased
  reg [`CWD_WORD_W-1:0] rdata_next;
  always @* begin
    rdata_next = {`CWD_WORD_W{1'b0}};
    if (rd_pend_reg && rd_ok_reg) begin
      rdata_next = rd_cell_reg ? cell_rdata : `CWD_ERASED;
    end
  end

  // Read data stand only in the cycle after the strobe; limitation: program array is not held here
  always @* begin
    rdata = rdata_next;
  end

  // ****************************************************************************
  // Decoded option outputs
  // ****************************************************************************
  // Registered so the consumers see clean levels; they follow the word one cycle late
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oscillator_source_select <= 1'b1;
      crystal_oscillator_mode  <= 1'b0;
      watchdog_enable          <= 1'b1;
      powerup_timer_enable_n   <= 1'b1;
      program_protect_hi       <= 1'b1;
      program_protect_lo       <= 1'b1;
      calib_space_protect      <= 1'b1;
      prog_read_allow          <= 1'b1;
      prog_write_allow         <= 1'b1;
      calib_write_allow        <= 1'b1;
      prog_write_pulse         <= 1'b0;
      access_error             <= 1'b0;
    end else begin
      oscillator_source_select <= cfg_reg[`CWD_BIT_OSC];
      crystal_oscillator_mode  <= ~cfg_reg[`CWD_BIT_OSC];
      watchdog_enable          <= cfg_reg[`CWD_BIT_WDT];
      powerup_timer_enable_n   <= cfg_reg[`CWD_BIT_PWRT];
      program_protect_hi       <= cfg_reg[`CWD_BIT_PROGRAM_PROTECT_HI];
      program_protect_lo       <= cfg_reg[`CWD_BIT_PROGRAM_PROTECT_LO];
      calib_space_protect      <= cfg_reg[`CWD_BIT_CPC];
      prog_read_allow          <= prog_ok_now;
      prog_write_allow         <= prog_ok_now;
      calib_write_allow        <= cal_wr_ok;
      prog_write_pulse         <= prog_wr;
      access_error             <= bad_wr | bad_rd;
    end
  end

endmodule // cwd_decoder

// file: core/cwd_defs.vh
// Constants for the configuration word decoder: addresses, field positions, erased value.
// Assumes inclusion by the decoder and memory design files, not the pin synchroniser; definitions only.
`ifndef CWD_DEFS_VH
`define CWD_DEFS_VH

// ****************************************************************************
// Address map
// ****************************************************************************
`define CWD_ADDR_W        14
`define CWD_CFG_ADDR      14'h2007
`define CWD_TEST_LO       14'h2000
`define CWD_TEST_HI       14'h3FFF
`define CWD_CAL_LO        14'h2000
`define CWD_CAL_HI        14'h2006
`define CWD_PROG_TOP      14'h0FFF

// ****************************************************************************
// Word layout
// ****************************************************************************
`define CWD_WORD_W        14
`define CWD_ERASED        14'h3FFF
`define CWD_RSVD_MASK     14'h3F42
`define CWD_BIT_OSC       0
`define CWD_BIT_WDT       2
`define CWD_BIT_PWRT      3
`define CWD_BIT_PROGRAM_PROTECT_LO      4
`define CWD_BIT_PROGRAM_PROTECT_HI      5
`define CWD_BIT_CPC       7

`endif

// file: core/cwd_pin_sync.v
// Three-flop synchroniser for a level from a pin.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/10ps

module cwd_pin_sync #(
  parameter RESET_VAL = 1'b0
) (
  input  wire mclk,
  input  wire rst_n,
  input  wire pin_in,
  output reg  level_out
);

  // ****************************************************************************
  // Synchroniser
  // ****************************************************************************
  reg meta_reg;
  reg s2_reg;
  reg s3_reg;

  // Change accepted only when stages two and three agree; first stage feeds only s2
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg  <= RESET_VAL;
      s2_reg    <= RESET_VAL;
      s3_reg    <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      meta_reg <= pin_in;
      s2_reg   <= meta_reg;
      s3_reg   <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end

endmodule // cwd_pin_sync

// file: core/cwd_word_mem.v
// Little memory holding the configuration word and its neighbours in test space.
// Assumes a single clock; read data come out of a register one cycle later.
`timescale 1ns/10ps
`include "cwd_defs.vh"

module cwd_word_mem #(
  parameter DEPTH_W = 3
) (
  input  wire                      mclk,
  input  wire                      rst_n,
  input  wire                      wr_en,
  input  wire [DEPTH_W-1:0]        wr_addr,
  input  wire [`CWD_WORD_W-1:0]    wr_data,
  input  wire [DEPTH_W-1:0]        rd_addr,
  output reg  [`CWD_WORD_W-1:0]    rd_data
);

  // ****************************************************************************
  // Storage
  // ****************************************************************************
  reg [`CWD_WORD_W-1:0] mem_reg [0:(1<<DEPTH_W)-1];
  integer i;

  // Erased cells read as all ones, like unprogrammed EPROM
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < (1<<DEPTH_W); i = i + 1) begin
        mem_reg[i] <= `CWD_ERASED;
      end
      rd_data <= `CWD_ERASED;
    end else begin
      if (wr_en) begin
        mem_reg[wr_addr] <= mem_reg[wr_addr] & wr_data;  // Programming only clears bits
      end
      rd_data <= mem_reg[rd_addr];
    end
  end

endmodule // cwd_word_mem

// file: sim/cwd_chk_props.sv
// Checker for the configuration word decoder, watching its ports only.
// Assumes cwd_defs.vh on the include path; bound to cwd_decoder below.
`timescale 1ns/10ps
`include "cwd_defs.vh"
module cwd_chk (
  input wire        mclk,
  input wire        rst_n,
  input wire        prog_mode_pin,
  input wire [13:0] addr,
  input wire [13:0] wdata,
  input wire        wr_stb,
  input wire        rd_stb,
  input wire [13:0] rdata,
  input wire        oscillator_source_select,
  input wire        crystal_oscillator_mode,
  input wire        watchdog_enable,
  input wire        powerup_timer_enable_n,
  input wire        program_protect_lo,
  input wire        calib_space_protect,
  input wire        prog_write_pulse,
  input wire        access_error
);
  // Pin run lengths; seven edges outlast the synchroniser lag
  reg  [2:0] hi_cnt;
  reg  [2:0] lo_cnt;
  wire       pm_on  = hi_cnt == 3'h7;
  wire       pm_off = lo_cnt == 3'h7;
  wire       cfg_wr = wr_stb && addr == `CWD_CFG_ADDR && pm_on;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt <= 3'h0;
      lo_cnt <= 3'h0;
    end else begin
      hi_cnt <= prog_mode_pin ? hi_cnt + {2'h0, pm_on == 1'b0} : 3'h0;
      lo_cnt <= prog_mode_pin ? 3'h0 : lo_cnt + {2'h0, pm_off == 1'b0};
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_sticky; !program_protect_lo |=> !program_protect_lo; endproperty
  a_sticky: assert property (p_sticky) else $error("protect bit came back");
  property p_rsvd; rd_stb && addr == `CWD_CFG_ADDR && pm_on |=> rdata[13:8] == 6'h3F && rdata[6] && rdata[1];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit low");
  property p_nomode; (wr_stb || rd_stb) && addr >= `CWD_TEST_LO && pm_off |=> access_error && rdata == 14'h0000;
  endproperty
  a_nomode: assert property (p_nomode) else $error("test space open");
  property p_calib; wr_stb && addr >= `CWD_CAL_LO && addr <= `CWD_CAL_HI && pm_on && !calib_space_protect
    |=> access_error; endproperty
  a_calib: assert property (p_calib) else $error("calibration write taken");
  property p_prog; wr_stb && addr <= `CWD_PROG_TOP && !program_protect_lo |=> access_error && !prog_write_pulse;
  endproperty
  a_prog: assert property (p_prog) else $error("program write taken");
  property p_pwrt; cfg_wr && !wdata[3] |-> ##2 !powerup_timer_enable_n; endproperty
  a_pwrt: assert property (p_pwrt) else $error("timer not on");
  property p_osc; cfg_wr && !wdata[0] |-> ##2 !oscillator_source_select && crystal_oscillator_mode; endproperty
  a_osc: assert property (p_osc) else $error("oscillator not crystal");
  property p_wdt; cfg_wr && !wdata[2] |-> ##2 !watchdog_enable; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog still on");
  c_cfg: cover property (cfg_wr);
  c_err: cover property (access_error);
  c_pulse: cover property (prog_write_pulse);
endmodule // cwd_chk

bind cwd_decoder cwd_chk cwd_chk_inst (.mclk(mclk), .rst_n(rst_n), .prog_mode_pin(prog_mode_pin), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .oscillator_source_select(oscillator_source_select),
  .crystal_oscillator_mode(crystal_oscillator_mode), .watchdog_enable(watchdog_enable),
  .powerup_timer_enable_n(powerup_timer_enable_n), .program_protect_lo(program_protect_lo),
  .calib_space_protect(calib_space_protect), .prog_write_pulse(prog_write_pulse), .access_error(access_error));

// file: sim/cwd_prog_model.sv
// Programmer model: drives the mode pin and the programming port.
// Assumes the bench calls one task at a time.
`timescale 1ns/10ps
module cwd_prog_model (
  input  wire        mclk,
  input  wire [13:0] rdata,
  input  wire        access_error,
  input  wire        prog_write_pulse,
  output reg         prog_mode_pin = 1'b0,
  output reg  [13:0] addr = 14'h0000,
  output reg  [13:0] wdata = 14'h0000,
  output reg         wr_stb = 1'b0,
  output reg         rd_stb = 1'b0
);
  // Mode change, then a wait longer than the synchroniser
  task set_mode(input m);
    begin
      @(posedge mclk) prog_mode_pin <= m;
      repeat (8) @(posedge mclk);
    end
  endtask
  // One strobe cycle; the answer stands only in the next cycle
  task xfer(input w, input [13:0] a, input [13:0] d, output [13:0] q, output [1:0] ep);
    begin
      @(posedge mclk);
      wr_stb <= w;
      rd_stb <= !w;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      addr <= ~a; // Idle lines must not keep the last value
      wdata <= ~d;
      #1;
      q = rdata;
      ep = {access_error, prog_write_pulse};
    end
  endtask
endmodule // cwd_prog_model

// file: sim/tb_top.sv
// Testbench for the configuration word decoder with a programmer model.
// Assumes design files and cwd_defs.vh on the include path.
`timescale 1ns/10ps
module tb_top;
  reg         mclk = 1'b0;
  reg         rst_n = 1'b0;
  wire        pm_pin, wr_stb, rd_stb, pw_pulse, acc_err;
  wire [13:0] addr, wdata, rdata;
  wire [9:0]  opts;
  reg  [13:0] q;
  reg  [1:0]  ep;
  integer     miscompares = 0;
  integer     n_tests = 0;
  always #12.5 mclk = ~mclk;
  cwd_decoder cwd_decoder_inst (.mclk(mclk), .rst_n(rst_n), .prog_mode_pin(pm_pin), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .oscillator_source_select(opts[9]),
    .crystal_oscillator_mode(opts[8]), .watchdog_enable(opts[7]), .powerup_timer_enable_n(opts[6]),
    .program_protect_hi(opts[5]), .program_protect_lo(opts[4]), .calib_space_protect(opts[3]),
    .prog_read_allow(opts[2]), .prog_write_allow(opts[1]), .calib_write_allow(opts[0]),
    .prog_write_pulse(pw_pulse), .access_error(acc_err));
  cwd_prog_model cwd_prog_model_inst (.mclk(mclk), .rdata(rdata), .access_error(acc_err),
    .prog_write_pulse(pw_pulse), .prog_mode_pin(pm_pin), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb));
  task chk(input [13:0] seen, input [13:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task xf(input w, input [13:0] a, input [13:0] d);
    cwd_prog_model_inst.xfer(w, a, d, q, ep);
  endtask
  // Options settle two edges after a config write
  task opt_chk(input [9:0] exp);
    begin
      @(posedge mclk);
      #1;
      chk(opts, exp);
    end
  endtask
  // Erased options; test space closed outside programming mode
  task t_closed;
    begin
      chk(opts, 10'h2FF);
      xf(1'b1, 14'h2007, 14'h0000);
      chk(ep, 2'b10);
      opt_chk(10'h2FF);
    end
  endtask
  // Config write clears options; reserved bits cannot be cleared
  task t_config;
    begin
      cwd_prog_model_inst.set_mode(1'b1);
      xf(1'b0, 14'h2007, 14'h0000);
      chk(q, 14'h3FFF);
      xf(1'b1, 14'h2007, 14'h00B0);
      opt_chk(10'h13F);
      xf(1'b0, 14'h2007, 14'h0000);
      chk(q, 14'h3FF2);
    end
  endtask
  // Protection bits gate calibration and program space
  task t_protect;
    begin
      xf(1'b1, 14'h0100, 14'h1234);
      chk(ep, 2'b01);
      xf(1'b1, 14'h2003, 14'h1234);
      chk(ep, 2'b00);
      xf(1'b1, 14'h2007, 14'h3F7F);
      opt_chk(10'h136);
      xf(1'b1, 14'h2003, 14'h1234);
      chk(ep, 2'b10);
      xf(1'b1, 14'h2007, 14'h3FEF);
      opt_chk(10'h120);
      xf(1'b1, 14'h0100, 14'h1234);
      chk(ep, 2'b10);
      xf(1'b0, 14'h0100, 14'h0000);
      chk(ep, 2'b10);
    end
  endtask
  // Leaving the mode closes test space; reset erases the word
  task t_leave;
    begin
      cwd_prog_model_inst.set_mode(1'b0);
      xf(1'b0, 14'h2007, 14'h0000);
      chk(ep, 2'b10);
      chk(q, 14'h0000);
      @(posedge mclk) rst_n <= 1'b0;
      @(posedge mclk) rst_n <= 1'b1;
      #1;
      chk(opts, 10'h2FF);
    end
  endtask
  task wrap_up;
    begin
      if (miscompares == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_closed;
    t_config;
    t_protect;
    t_leave;
    wrap_up;
  end
  // Hang guard bounds the whole run
  initial begin
    repeat (4000) @(posedge mclk);
    miscompares = miscompares + 1;
    wrap_up;
  end
endmodule // tb_top
